// *** src/emiwsp_pkg.sv ***
// Package for the write strobe and preset configuration block of the memory interface
`default_nettype none
package emiwsp_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_ADDR_OFS   = 8'h04;
  localparam logic [7:0] REG_WDATA_OFS  = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
  localparam logic [7:0] REG_CONFIG_OFS = 8'h10;
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_INT_BIT   = 1;
  localparam int CTRL_LANE_LSB  = 4;
  localparam int CTRL_WAIT_LSB  = 8;

  // ****************************************************************
  // Timing constants
  // ****************************************************************
  localparam logic [7:0]  TM_CYC        = 8'h01;   // Clocks per unit period
  localparam logic [7:0]  SCAN_WIN_CYC  = 8'h90;   // 144 clocks of scan window
  localparam logic [7:0]  SCAN_SPAN_CYC = 8'h40;   // 64 clocks of line falls
  localparam logic [7:0]  SCAN_STEP_CYC = 8'h02;   // Two clocks between falls
  localparam logic [7:0]  FALL_OFS_CYC  = 8'h02;   // First line falls here
  localparam logic [7:0]  SENSE_LAT_CYC = 8'h04;   // Fall offset plus two sync flops
  localparam logic [4:0]  DEF_LINE      = 5'h1F;   // Top address line entry
  localparam logic [6:0]  REFRESH_CLK   = 7'h48;   // 72 input clocks
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_T1 = 3'b001, PH_T2 = 3'b010, PH_T3 = 3'b011,
    PH_T4 = 3'b100, PH_T5 = 3'b101, PH_T6 = 3'b110, PH_WAIT = 3'b111
  } emiwsp_ph_e;

  typedef struct packed {
    logic [5:0][2:0] tlen;      // Units per Tstate, index 0 is T1
    logic [4:0]      s1;
    logic [4:0]      s2;
    logic [4:0]      s3;
    logic [4:0]      s4;
    logic            early;
    logic            refresh_en;
    logic [6:0]      refresh_ivl;
  } emiwsp_cfg_s;

  typedef struct packed {
    logic [29:0] addr;
    logic [31:0] data;
    logic [3:0]  lanes;
    logic        internal;
    logic [7:0]  wait_units;
  } emiwsp_req_s;

  // ****************************************************************
  // Preset table
  // ****************************************************************
  function automatic emiwsp_cfg_s mk(input int t1, t2, t3, t4, t5, t6,
                                     input int s1, s2, s3, s4,
                                     input logic early, input logic refr);
    emiwsp_cfg_s c;
    c.tlen        = {3'(t6), 3'(t5), 3'(t4), 3'(t3), 3'(t2), 3'(t1)};
    c.s1          = 5'(s1);
    c.s2          = 5'(s2);
    c.s3          = 5'(s3);
    c.s4          = 5'(s4);
    c.early       = early;
    c.refresh_en  = refr;
    c.refresh_ivl = refr ? REFRESH_CLK : 7'h00;
    return c;
  endfunction

  // Entry for a scanned line; lines without an entry give the default
  function automatic emiwsp_cfg_s preset(input logic [4:0] line);
    unique case (line)
      5'd0:    preset = mk(1, 1, 1, 1, 1, 1, 30, 1, 3, 5, 1'b0, 1'b1);
      5'd1:    preset = mk(1, 2, 1, 1, 1, 2, 30, 1, 2, 7, 1'b0, 1'b1);
      5'd2:    preset = mk(1, 2, 1, 1, 2, 3, 30, 1, 2, 7, 1'b0, 1'b1);
      5'd3:    preset = mk(2, 3, 1, 1, 2, 3, 30, 1, 3, 8, 1'b0, 1'b1);
      5'd4:    preset = mk(1, 1, 1, 1, 1, 1, 3, 1, 2, 3, 1'b1, 1'b1);
      5'd5:    preset = mk(1, 1, 2, 1, 2, 1, 5, 1, 2, 3, 1'b1, 1'b1);
      5'd6:    preset = mk(2, 1, 2, 1, 3, 1, 6, 1, 2, 3, 1'b1, 1'b1);
      5'd7:    preset = mk(2, 2, 2, 1, 3, 2, 7, 1, 3, 4, 1'b1, 1'b1);
      5'd8:    preset = mk(1, 1, 1, 1, 1, 1, 30, 1, 2, 3, 1'b1, 1'b0);
      5'd9:    preset = mk(1, 1, 2, 1, 2, 1, 30, 2, 5, 9, 1'b1, 1'b0);
      5'd10:   preset = mk(2, 2, 2, 2, 4, 2, 30, 2, 3, 8, 1'b0, 1'b1);
      5'd11:   preset = mk(3, 3, 3, 3, 3, 3, 30, 2, 4, 13, 1'b0, 1'b1);
      5'd12:   preset = mk(1, 1, 2, 1, 2, 1, 4, 1, 2, 3, 1'b1, 1'b1);
      5'd13:   preset = mk(2, 1, 2, 1, 2, 2, 5, 1, 2, 3, 1'b1, 1'b1);
      5'd14:   preset = mk(2, 2, 2, 1, 3, 2, 6, 1, 3, 4, 1'b1, 1'b1);
      5'd15:   preset = mk(2, 1, 2, 3, 3, 3, 8, 1, 2, 3, 1'b1, 1'b1);
      default: preset = mk(4, 4, 4, 4, 4, 4, 31, 30, 30, 18, 1'b0, 1'b1);
    endcase
  endfunction

endpackage
`default_nettype wire

// *** src/emiwsp_top.sv ***
// Write strobe generator and preset configuration scan of the memory interface
//
// Design decisions made here: the address-and-strobe port and the address map.
`default_nettype none
module emiwsp_top
  import emiwsp_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  input  wire logic        CONFIG_SENSE_INPUT_I,
  output logic      [3:0]  BYTE_WRITE_STROBE_N_O,
  output logic             WRITE_FLAG_DATA0_LINE_O,
  output logic             WRITE_FLAG_DATA0_LINE_OE_N_O,
  output logic             REFRESH_FLAG_DATA1_LINE_O,
  output logic             REFRESH_FLAG_DATA1_LINE_OE_N_O,
  output logic      [29:0] MUXED_ADDRESS_DATA_LINES_O,
  output logic      [29:0] MUXED_ADDRESS_DATA_LINES_OE_N_O,
  output emiwsp_pkg::emiwsp_cfg_s CONFIG_O
);
  import emiwsp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  emiwsp_ph_e  ph_r, ph_nxt;
  emiwsp_req_s req_r, req_nxt;
  emiwsp_cfg_s cfg_r, cfg_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic [7:0]  scan_cnt_r, scan_cnt_nxt;
  logic        scan_act_r, scan_act_nxt;
  logic        matched_r, matched_nxt;
  logic        ext_req_r, ext_req_nxt;
  logic [4:0]  line_r, line_nxt;
  logic        sense_s1_r, sense_s2_r;
  logic [29:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_nxt;
  logic [3:0]  strobe_n_nxt;
  logic [31:0] bus_out_nxt, bus_oe_n_nxt;
  logic [31:0] bus_out_r, bus_oe_n_r;
  logic [15:0] ph_len;
  logic        ph_end;
  logic        go;
  logic        busy;
  logic        strobe_ph;
  logic        data_ph;
  logic        addr_ph;
  logic [7:0]  sense_line;

  // Clocks that one Tstate of the given index lasts
  function automatic logic [15:0] ts_clk(input emiwsp_cfg_s c, input int idx);
    ts_clk = 16'({13'h0000, c.tlen[idx]} * {8'h00, TM_CYC});
  endfunction

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  assign go   = WR_I && (ADDR_I == REG_CTRL_OFS) && WDATA_I[CTRL_GO_BIT];
  assign busy = (ph_r != PH_IDLE);

  // Unmapped reads return zero
  always_comb begin
    unique case (ADDR_I)
      REG_CTRL_OFS:   rdata_nxt = {16'h0000, req_r.wait_units, req_r.lanes, 2'b00,
                                   req_r.internal, busy};
      REG_ADDR_OFS:   rdata_nxt = {addr_r, 2'b00};
      REG_WDATA_OFS:  rdata_nxt = wdata_r;
      REG_STATUS_OFS: rdata_nxt = {19'h0_0000, line_r, 4'h0, ext_req_r, matched_r,
                                   ~scan_act_r, busy};
      REG_CONFIG_OFS: rdata_nxt = {cfg_r.early, cfg_r.refresh_en, cfg_r.refresh_ivl,
                                   cfg_r.s1, cfg_r.tlen};
      default:        rdata_nxt = RESET_WORD;
    endcase
  end

  // Address and data registers; read data one cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      addr_r  <= 30'h0000_0000;
      wdata_r <= RESET_WORD;
      RDATA_O <= RESET_WORD;
    end else begin
      if (WR_I && ADDR_I == REG_ADDR_OFS) addr_r <= WDATA_I[31:2];
      if (WR_I && ADDR_I == REG_WDATA_OFS) wdata_r <= WDATA_I;
      RDATA_O <= RD_I ? rdata_nxt : RESET_WORD;
    end
  end

  // ****************************************************************
  // Sense input synchroniser
  // ****************************************************************
  // Pin is asynchronous to our clock, so two flops before any use
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sense_s1_r <= 1'b1;
      sense_s2_r <= 1'b1;
    end else begin
      sense_s1_r <= CONFIG_SENSE_INPUT_I;
      sense_s2_r <= sense_s1_r;
    end
  end

  // ****************************************************************
  // Internal configuration scan
  // ****************************************************************
  // Line index whose fall is now seen on the synchronised input
  assign sense_line = 8'((scan_cnt_r - SENSE_LAT_CYC) >> 1);

  always_comb begin
    scan_act_nxt = scan_act_r;
    scan_cnt_nxt = scan_cnt_r;
    matched_nxt  = matched_r;
    ext_req_nxt  = ext_req_r;
    line_nxt     = line_r;
    cfg_nxt      = cfg_r;
    if (scan_act_r) begin
      scan_cnt_nxt = scan_cnt_r + 8'h01;
      if (scan_cnt_r == SCAN_WIN_CYC - 8'h01) begin
        scan_act_nxt = 1'b0;
      end
      if (!sense_s2_r && !matched_r && !ext_req_r) begin
        if (scan_cnt_r < SENSE_LAT_CYC) begin
          // Held low before any fall: an external load is wanted instead
          ext_req_nxt = 1'b1;
        end else if (scan_cnt_r < SENSE_LAT_CYC + SCAN_SPAN_CYC) begin
          matched_nxt = 1'b1;
          line_nxt    = sense_line[4:0];
          cfg_nxt     = preset(sense_line[4:0]);
          // Taken only while no external request is pending, so ext_req_nxt stays clear
          ext_req_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      scan_act_r <= 1'b1;
      scan_cnt_r <= 8'h00;
      matched_r  <= 1'b0;
      ext_req_r  <= 1'b0;
      line_r     <= DEF_LINE;
      cfg_r      <= preset(DEF_LINE);
    end else begin
      scan_act_r <= scan_act_nxt;
      scan_cnt_r <= scan_cnt_nxt;
      matched_r  <= matched_nxt;
      ext_req_r  <= ext_req_nxt;
      line_r     <= line_nxt;
      cfg_r      <= cfg_nxt;
    end
  end

  // ****************************************************************
  // Write cycle sequencer
  // ****************************************************************
  // Length of the current phase in clocks
  always_comb begin
    unique case (ph_r)
      PH_T1:   ph_len = ts_clk(cfg_r, 0);
      PH_T2:   ph_len = ts_clk(cfg_r, 1);
      PH_T3:   ph_len = ts_clk(cfg_r, 2);
      PH_T4:   ph_len = ts_clk(cfg_r, 3);
      PH_T5:   ph_len = ts_clk(cfg_r, 4);
      PH_T6:   ph_len = ts_clk(cfg_r, 5);
      PH_WAIT: ph_len = 16'({8'h00, req_r.wait_units} * {8'h00, TM_CYC});
      PH_IDLE: ph_len = 16'h0001;
    endcase
  end
  assign ph_end = (tcnt_r == ph_len - 16'h0001);

  // Starts are refused during the scan and while a cycle runs
  always_comb begin
    ph_nxt   = ph_r;
    tcnt_nxt = ph_end ? 16'h0000 : tcnt_r + 16'h0001;
    req_nxt  = req_r;
    unique case (ph_r)
      PH_IDLE: begin
        tcnt_nxt = 16'h0000;
        if (go && !scan_act_r) begin
          ph_nxt             = PH_T1;
          req_nxt.addr       = addr_r;
          req_nxt.data       = wdata_r;
          req_nxt.lanes      = WDATA_I[CTRL_LANE_LSB +: 4];
          req_nxt.internal   = WDATA_I[CTRL_INT_BIT];
          req_nxt.wait_units = WDATA_I[CTRL_WAIT_LSB +: 8];
        end
      end
      PH_T1:   if (ph_end) ph_nxt = PH_T2;
      PH_T2:   if (ph_end) ph_nxt = PH_T3;
      PH_T3:   if (ph_end) ph_nxt = PH_T4;
      PH_T4: begin
        if (ph_end) begin
          ph_nxt = (req_r.wait_units != 8'h00) ? PH_WAIT : PH_T5;
        end
      end
      PH_WAIT: if (ph_end) ph_nxt = PH_T5;
      PH_T5:   if (ph_end) ph_nxt = PH_T6;
      PH_T6:   if (ph_end) ph_nxt = PH_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ph_r   <= PH_IDLE;
      tcnt_r <= 16'h0000;
      req_r  <= '0;
    end else begin
      ph_r   <= ph_nxt;
      tcnt_r <= tcnt_nxt;
      req_r  <= req_nxt;
    end
  end

  // ****************************************************************
  // Pin decode, from the next phase so pins line up with ph_r
  // ****************************************************************
  assign strobe_ph = (ph_nxt == PH_T4) || (ph_nxt == PH_WAIT) || (ph_nxt == PH_T5) ||
                     ((ph_nxt == PH_T3) && cfg_r.early);
  assign data_ph   = (ph_nxt == PH_T3) || (ph_nxt == PH_T4) || (ph_nxt == PH_WAIT) ||
                     (ph_nxt == PH_T5) || (ph_nxt == PH_T6);
  assign addr_ph   = (ph_nxt == PH_T1) || (ph_nxt == PH_T2);

  // Internal cycles never reach the strobe pins
  assign strobe_n_nxt = (strobe_ph && !req_nxt.internal) ? ~req_nxt.lanes
                                                         : 4'hF;

  // Bit 0 is the write flag line, bit 1 the refresh flag line
  always_comb begin
    bus_out_nxt  = 32'hFFFF_FFFF;
    bus_oe_n_nxt = 32'hFFFF_FFFF;
    if (scan_act_nxt) begin
      for (int k = 0; k < 32; k++) begin
        bus_oe_n_nxt[k] = 1'b0;
        bus_out_nxt[k]  = (scan_cnt_nxt < FALL_OFS_CYC + 8'(k) * SCAN_STEP_CYC);
      end
    end else if (addr_ph) begin
      bus_oe_n_nxt = 32'h0000_0000;
      bus_out_nxt  = {req_nxt.addr, 1'b1, 1'b0};
    end else if (data_ph) begin
      bus_out_nxt = req_nxt.data;
      for (int k = 0; k < 4; k++) begin
        bus_oe_n_nxt[8*k +: 8] = {8{~req_nxt.lanes[k]}};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      BYTE_WRITE_STROBE_N_O <= 4'hF;
      bus_out_r             <= 32'hFFFF_FFFF;
      bus_oe_n_r            <= 32'hFFFF_FFFF;
      CONFIG_O              <= preset(DEF_LINE);
    end else begin
      BYTE_WRITE_STROBE_N_O <= strobe_n_nxt;
      bus_out_r             <= bus_out_nxt;
      bus_oe_n_r            <= bus_oe_n_nxt;
      CONFIG_O              <= cfg_nxt;
    end
  end

  assign WRITE_FLAG_DATA0_LINE_O         = bus_out_r[0];
  assign WRITE_FLAG_DATA0_LINE_OE_N_O    = bus_oe_n_r[0];
  assign REFRESH_FLAG_DATA1_LINE_O       = bus_out_r[1];
  assign REFRESH_FLAG_DATA1_LINE_OE_N_O  = bus_oe_n_r[1];
  assign MUXED_ADDRESS_DATA_LINES_O      = bus_out_r[31:2];
  assign MUXED_ADDRESS_DATA_LINES_OE_N_O = bus_oe_n_r[31:2];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  strobe_lanes_a: assert property (
    (~BYTE_WRITE_STROBE_N_O & ~req_r.lanes) == 4'h0)
    else $error("strobe low on a lane that is not written");

  lane_float_a: assert property (
    (ph_r == PH_T4 && !scan_act_r) |-> (bus_oe_n_r[7:0] == {8{~req_r.lanes[0]}}))
    else $error("unwritten lane not floated");

  late_strobe_a: assert property (
    (ph_r == PH_T4 && !req_r.internal) |-> (BYTE_WRITE_STROBE_N_O == ~req_r.lanes))
    else $error("strobe not low in T4");

  early_t3_a: assert property (
    (ph_r == PH_T3 && !req_r.internal) |->
      (BYTE_WRITE_STROBE_N_O == (cfg_r.early ? ~req_r.lanes : 4'hF)))
    else $error("T3 strobe wrong for write type");

  data_hold_a: assert property (
    (ph_r == PH_T6 && req_r.lanes[3]) |-> (bus_oe_n_r[31:24] == 8'h00 &&
      bus_out_r[31:24] == req_r.data[31:24]))
    else $error("data not held through T6");

  t4_len_a: assert property (
    (ph_r == PH_T4 && ph_nxt != PH_T4) |-> (tcnt_r == ts_clk(cfg_r, 3) - 16'h0001))
    else $error("T4 length wrong");

  wait_strobe_a: assert property (
    (ph_r == PH_WAIT && !req_r.internal) |->
      (req_r.wait_units != 8'h00 && BYTE_WRITE_STROBE_N_O == ~req_r.lanes))
    else $error("strobe not extended by wait");

  internal_high_a: assert property (
    req_r.internal |-> (BYTE_WRITE_STROBE_N_O == 4'hF))
    else $error("strobe active on internal cycle");

  scan_first_a: assert property (
    (scan_act_r && scan_cnt_r == 8'h03) |->
      (!WRITE_FLAG_DATA0_LINE_O && REFRESH_FLAG_DATA1_LINE_O) ##2 !REFRESH_FLAG_DATA1_LINE_O)
    else $error("scan line order wrong");

  scan_end_a: assert property (
    $fell(scan_act_r) |-> ($past(scan_cnt_r) == SCAN_WIN_CYC - 8'h01))
    else $error("scan window length wrong");

  default_cfg_a: assert property (
    (!scan_act_r && !matched_r) |-> (cfg_r == preset(DEF_LINE)))
    else $error("default configuration not kept");

  scan_start_a: assert property (
    (scan_act_r && scan_cnt_r == 8'h01) |->
      (bus_out_r == 32'hFFFF_FFFF && bus_oe_n_r == 32'h0000_0000))
    else $error("lines not all driven high at scan start");

  match_line_a: assert property (
    $rose(matched_r) |-> ($past(scan_cnt_r) == SENSE_LAT_CYC + 8'({line_r, 1'b0})))
    else $error("latched line does not match first sensed fall");

  write_flag_a: assert property (
    (ph_r == PH_T1 || ph_r == PH_T2) |->
      (!WRITE_FLAG_DATA0_LINE_O && !WRITE_FLAG_DATA0_LINE_OE_N_O && REFRESH_FLAG_DATA1_LINE_O))
    else $error("write flag not low in T1 and T2");

  // Main scenarios: early write, wait stretch, preset pick, external request
  early_cov_c: cover property (ph_r == PH_T3 && cfg_r.early && !req_r.internal);
  wait_cov_c:  cover property (ph_r == PH_WAIT ##[1:40] ph_r == PH_T6);
  match_cov_c: cover property ($rose(matched_r));
  ext_cov_c:   cover property ($rose(ext_req_r));

endmodule // emiwsp_top
`default_nettype wire

// *** verification/emiwsp_mem_model.sv ***
// Behavioural external memory and sense-pin wiring on the far side of the interface
`default_nettype none
module emiwsp_mem_model (
  input  wire logic [3:0]  strobe_n_i,
  input  wire logic [31:0] line_i,
  input  wire logic [31:0] line_oe_n_i,
  input  wire logic [5:0]  sel_i,
  output logic             sense_o,
  output logic [31:0]      cap_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] prev_r = 4'hF;

  // Released lines sit at their pull-up level, never at the last value
  wire logic [31:0] seen = line_i | line_oe_n_i;

  // Sense pin wired to one line; 63 ties it high, 62 ties it low
  assign sense_o = (sel_i == 6'h3F) ? 1'b1 : (sel_i == 6'h3E) ? 1'b0 : seen[sel_i[4:0]];

  // Each byte is taken on the rising edge of its own strobe only
  always @(strobe_n_i) begin
    for (int k = 0; k < 4; k++) begin
      if (!prev_r[k] && strobe_n_i[k]) cap_o[8*k +: 8] = seen[8*k +: 8];
    end
    prev_r = strobe_n_i;
  end
endmodule // emiwsp_mem_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the preset scan and the byte write strobes
`default_nettype none
module tb import emiwsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and scenario table
  // ****************************************************************
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [5:0]  sel   = 6'h3F;
  logic        sense, wf, wf_oe_n, rf, rf_oe_n;
  logic [31:0] rdata, cap;
  logic [29:0] bus, bus_oe_n;
  logic [3:0]  strobe_n;
  emiwsp_cfg_s cfg;
  int          compares   = 0;
  int          n_mismatch = 0;
  logic [5:0]  sels  [7] = '{6'h00, 6'h04, 6'h09, 6'h0F, 6'h14, 6'h3F, 6'h3E};
  logic [3:0]  lanes [7] = '{4'hF, 4'h5, 4'hA, 4'h1, 4'h8, 4'h3, 4'hC};
  logic [7:0]  waits [7] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h03, 8'h00, 8'h01};

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  emiwsp_top dut (
    .CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .CONFIG_SENSE_INPUT_I(sense), .BYTE_WRITE_STROBE_N_O(strobe_n),
    .WRITE_FLAG_DATA0_LINE_O(wf), .WRITE_FLAG_DATA0_LINE_OE_N_O(wf_oe_n),
    .REFRESH_FLAG_DATA1_LINE_O(rf), .REFRESH_FLAG_DATA1_LINE_OE_N_O(rf_oe_n),
    .MUXED_ADDRESS_DATA_LINES_O(bus), .MUXED_ADDRESS_DATA_LINES_OE_N_O(bus_oe_n),
    .CONFIG_O(cfg)
  );

  emiwsp_mem_model mem (
    .strobe_n_i(strobe_n), .line_i({bus, rf, wf}), .line_oe_n_i({bus_oe_n, rf_oe_n, wf_oe_n}),
    .sel_i(sel), .sense_o(sense), .cap_o(cap)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Expected preset per sensed line; anything unlisted falls back to the default
  function automatic emiwsp_cfg_s xc(input logic [5:0] line);
    case (line)
      6'h00:   xc = {{6{3'h1}}, 5'h1E, 5'h01, 5'h03, 5'h05, 1'b0, 1'b1, 7'h48};
      6'h04:   xc = {{6{3'h1}}, 5'h03, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1, 7'h48};
      6'h09:   xc = {18'o12_1211, 5'h1E, 5'h02, 5'h05, 5'h09, 1'b1, 1'b0, 7'h00};
      6'h0F:   xc = {18'o33_3212, 5'h08, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1, 7'h48};
      default: xc = {{6{3'h4}}, 5'h1F, 5'h1E, 5'h1E, 5'h12, 1'b0, 1'b1, 7'h48};
    endcase
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register bus: one-cycle strobes, an idle edge after each access
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  // One write cycle, external or internal; strobe timing measured cycle by cycle from the go edge
  task automatic wcycle(input emiwsp_cfg_s c, input logic [3:0] ln, input logic [7:0] wt,
                        input logic intl, input logic [31:0] d);
    int          first, len, hold, total, ex_first, ex_len;
    logic [31:0] ex_oe;
    first = 0;
    len = 0;
    hold = 0;
    total = wt + c.tlen[0] + c.tlen[1] + c.tlen[2] + c.tlen[3] + c.tlen[4] + c.tlen[5];
    ex_first = c.tlen[0] + c.tlen[1] + (c.early ? 0 : c.tlen[2]) + 1;
    ex_len = (c.early ? c.tlen[2] : 0) + c.tlen[3] + c.tlen[4] + wt;
    for (int k = 0; k < 4; k++) ex_oe[8*k +: 8] = {8{~ln[k]}};
    wr_reg(REG_ADDR_OFS, 32'h0000_1230);
    wr_reg(REG_WDATA_OFS, d);
    addr <= REG_CTRL_OFS;
    wdata <= {16'h0000, wt, ln, 2'b00, intl, 1'b1};
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    for (int i = 1; i <= total + 2; i++) begin
      @(negedge clk);
      if (i == 1 && !intl) chk("write flag in T1", 0, {wf_oe_n, wf});
      if (strobe_n !== 4'hF) begin
        if (first == 0) first = i;
        len++;
        chk("strobe lanes", 4'(~ln), strobe_n);
        chk("lane drive", ex_oe, {bus_oe_n, rf_oe_n, wf_oe_n});
      end else if (len > 0 && {bus_oe_n, rf_oe_n, wf_oe_n} !== 32'hFFFF_FFFF) begin
        hold++;
      end
    end
    @(posedge clk);
    if (intl) begin
      chk("strobes on internal cycle", 0, len);
    end else begin
      chk("strobe start", ex_first, first);
      chk("strobe width", ex_len, len);
      chk("data hold", c.tlen[5], hold);
      chk("captured lanes", 32'(d & ~ex_oe), 32'(cap & ~ex_oe));
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence: one reset and scan per sensed line, then a write
  // ****************************************************************
  initial begin : main
    emiwsp_cfg_s ec;
    logic [31:0] st;
    for (int r = 0; r < 7; r++) begin
      ec = xc(sels[r]);
      sel <= sels[r];
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("strobes in reset", 4'hF, strobe_n);
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("lines high at scan start", 32'hFFFF_FFFF,
          32'({bus, rf, wf} & ~{bus_oe_n, rf_oe_n, wf_oe_n}));
      @(posedge clk);
      st = 32'h0000_0000;
      for (int k = 0; k < 100 && st[1] !== 1'b1; k++) rd_reg(REG_STATUS_OFS, st);
      if (st[1] !== 1'b1) begin
        n_mismatch++;
        $display("CHECK FAILED scan done expected 1 seen %b", st[1]);
        close_out();
      end
      chk("external request", sels[r] == 6'h3E, st[3]);
      chk("preset", ec, cfg);
      rd_reg(REG_CONFIG_OFS, st);
      chk("config reg", {ec.early, ec.refresh_en, ec.refresh_ivl, ec.s1, ec.tlen}, st);
      wcycle(ec, lanes[r], waits[r], 1'b0, 32'h1357_9BDF ^ {4{sels[r], 2'b00}});
      $display("Test with sense on line %0d done", sels[r]);
    end
    wcycle(ec, 4'hF, 8'h00, 1'b1, 32'h2468_ACE0);
    wr_reg(8'h24, 32'hFFFF_FFFF);
    rd_reg(8'h24, st);
    chk("unmapped read", 0, st);
    $display("Test of internal cycle and unmapped access done");
    close_out();
  end

  // Bound on the whole run
  initial begin : watchdog
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED run length expected done seen timeout");
    close_out();
  end
endmodule // tb
`default_nettype wire
